// [src/clkctl_params.svh]
// Constants for the clock controller: offsets, fields, reset values.
// Assumes inclusion by the package, the top module and the bench.
`ifndef CLKCTL_PARAMS_SVH
`define CLKCTL_PARAMS_SVH
`define OFF_PCLK_SET 12'h010
`define OFF_PCLK_CLR 12'h014
`define OFF_PCLK_STATE 12'h018
`define OFF_OSC_CTRL 12'h020
`define OFF_FREQ_MEAS 12'h024
`define OFF_PLL_A 12'h028
`define OFF_PLL_B 12'h02C
`define OFF_MCK_CFG 12'h030
`define OFF_STATUS 12'h068
`define RST_OSC_CTRL 32'h00000000
`define RST_PLL 32'h00003F00
`define RST_MCK_CFG 32'h00000000
`define PCLK_VALID_MASK 32'hFFFFFFFC
`define OSC_EN_BIT 0
`define OSC_BYP_BIT 1
`define OSC_CNT_LSB 8
`define MEAS_RDY_BIT 16
`define PLL_CNT_LSB 8
`define PLL_RANGE_LSB 14
`define PLL_MUL_LSB 16
`define PLL_USB_BIT 28
`define MCK_MASTER_PRESCALER_LSB 2
`define MCK_RATIO_LSB 8
`define OSC_STEP_CYCLES 8
`define MEAS_WINDOW_SLOW 16
`define ST_STABLE_BIT 0
`define ST_LOCK_A_BIT 1
`define ST_LOCK_B_BIT 2
`define ST_MCK_RDY_BIT 3
`endif

// [src/clkctl_pkg.sv]
// Types for the clock controller.
// Assumes nothing beyond the constants header.
`default_nettype none
`include "clkctl_params.svh"
package clkctl_pkg;
	typedef enum logic [1:0] {SRC_SLOW, SRC_MAIN, SRC_PLLA, SRC_PLLB} mck_src_e;
	typedef logic [31:0] word_t;
endpackage
`default_nettype wire

// [src/clkctl_top.sv]
// Clock generator and master clock controller with APB register access.
// Assumes all clock inputs sampled as synchronous levels of CLOCK_IN.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`include "clkctl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module clkctl_top #(
	parameter int CNT_W = 16
) (
	input wire logic CLOCK_IN,
	input wire logic NRST_IN,
	input wire logic CLKEN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic SLOW_CLK_IN,
	input wire logic MAIN_CLK_IN,
	input wire logic PLLA_CLK_IN,
	input wire logic PLLB_CLK_IN,
	output logic [31:0] PERIPH_CLK_EN_OUT,
	output logic MASTER_CLK_OUT,
	output logic USB_CLK_OUT,
	output clkctl_pkg::word_t PLLA_CFG_OUT,
	output clkctl_pkg::word_t PLLB_CFG_OUT,
	output logic [1:0] PROC_RATIO_OUT,
	output logic CFG_RESERVED_OUT
);
	import clkctl_pkg::*;

	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	////////////////////////////////////////////////////////////////
	logic wr_en, ack;
	logic [31:0] pclk_q, osc_q, plla_q, pllb_q, mck_q;
	logic stable_q, lock_a_q, lock_b_q, meas_rdy_q, mck_rdy_q;
	logic [15:0] meas_q;
	assign ack = PSEL_IN & PENABLE_IN;
	assign wr_en = ack & PWRITE_IN & CLKEN_IN;
	assign PREADY_OUT = 1'b1;

	function automatic logic known(input logic [11:0] a);
		case (a)
			`OFF_PCLK_SET, `OFF_PCLK_CLR, `OFF_PCLK_STATE, `OFF_OSC_CTRL, `OFF_FREQ_MEAS,
			`OFF_PLL_A, `OFF_PLL_B, `OFF_MCK_CFG, `OFF_STATUS: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	assign PSLVERR_OUT = ack & ~known(PADDR_IN);

	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			PRDATA_OUT <= 32'h00000000;
		end else if (CLKEN_IN && PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
			case (PADDR_IN)
				`OFF_PCLK_STATE: PRDATA_OUT <= pclk_q;
				`OFF_OSC_CTRL: PRDATA_OUT <= osc_q;
				`OFF_FREQ_MEAS: PRDATA_OUT <= {15'h0000, meas_rdy_q, meas_q};
				`OFF_PLL_A: PRDATA_OUT <= plla_q;
				`OFF_PLL_B: PRDATA_OUT <= pllb_q;
				`OFF_MCK_CFG: PRDATA_OUT <= mck_q;
				`OFF_STATUS: PRDATA_OUT <= {28'h0000000, mck_rdy_q, lock_b_q, lock_a_q, stable_q};
				default: PRDATA_OUT <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pclk_q <= 32'h00000000;
		end else if (wr_en && PADDR_IN == `OFF_PCLK_SET) begin
			pclk_q <= pclk_q | (PWDATA_IN & `PCLK_VALID_MASK);
		end else if (wr_en && PADDR_IN == `OFF_PCLK_CLR) begin
			pclk_q <= pclk_q & ~(PWDATA_IN & `PCLK_VALID_MASK);
		end
	end
	// enables change only at system clock edge
	assign PERIPH_CLK_EN_OUT = pclk_q;

	logic cfg_a_wr, cfg_b_wr, mck_wr;
	assign cfg_a_wr = wr_en && PADDR_IN == `OFF_PLL_A;
	assign cfg_b_wr = wr_en && PADDR_IN == `OFF_PLL_B;
	assign mck_wr = wr_en && PADDR_IN == `OFF_MCK_CFG;
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			osc_q <= `RST_OSC_CTRL;
			plla_q <= `RST_PLL;
			pllb_q <= `RST_PLL;
			mck_q <= `RST_MCK_CFG;
		end else begin
			if (wr_en && PADDR_IN == `OFF_OSC_CTRL) osc_q <= PWDATA_IN & 32'h0000FF03;
			// divider, range, multiplier fields kept whole
			if (cfg_a_wr) plla_q <= PWDATA_IN & 32'h07FFFFFF;
			// halve bit kept in B only
			if (cfg_b_wr) pllb_q <= PWDATA_IN & 32'h17FFFFFF;
			if (mck_wr) mck_q <= PWDATA_IN & 32'h0000031F;
		end
	end
	assign PLLA_CFG_OUT = plla_q;
	assign PLLB_CFG_OUT = pllb_q;
	// ratio driven to processor clock logic
	assign PROC_RATIO_OUT = mck_q[`MCK_RATIO_LSB +: 2];
	// reserved range or prescaler codes flagged
	// equal rewrites still restart lock counting
	assign CFG_RESERVED_OUT = plla_q[`PLL_RANGE_LSB] | pllb_q[`PLL_RANGE_LSB] | (&mck_q[4:2]);

	////////////////////////////////////////////////////////////////
	logic slow_q, slow_tick, main_q, main_tick;
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			slow_q <= 1'b0;
			main_q <= 1'b0;
		end else if (CLKEN_IN) begin
			slow_q <= SLOW_CLK_IN;
			main_q <= MAIN_CLK_IN;
		end
	end
	assign slow_tick = CLKEN_IN & rise(SLOW_CLK_IN, slow_q);
	assign main_tick = CLKEN_IN & rise(MAIN_CLK_IN, main_q);

	logic osc_en, osc_byp;
	logic [11:0] osc_cnt_q;
	assign osc_en = osc_q[`OSC_EN_BIT];
	assign osc_byp = osc_q[`OSC_BYP_BIT];
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			osc_cnt_q <= 12'h000;
			stable_q <= 1'b0;
		end else if (CLKEN_IN) begin
			if (!osc_en && !osc_byp) begin
				stable_q <= 1'b0;
				osc_cnt_q <= 12'h000;
			end else if (osc_byp) begin
				stable_q <= 1'b1;
			end else if (!stable_q && slow_tick) begin
				if (osc_cnt_q + 12'h001 >= 12'(osc_q[15:8]) * 12'(`OSC_STEP_CYCLES)) begin
					stable_q <= 1'b1;
				end else begin
					osc_cnt_q <= osc_cnt_q + 12'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	logic [4:0] win_q;
	logic [15:0] acc_q;
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			win_q <= 5'h00;
			acc_q <= 16'h0000;
			meas_q <= 16'h0000;
			meas_rdy_q <= 1'b0;
		end else if (CLKEN_IN) begin
			if (!osc_en && !osc_byp) begin
				win_q <= 5'h00;
				acc_q <= 16'h0000;
				meas_rdy_q <= 1'b0;
			end else begin
				if (main_tick) acc_q <= acc_q + 16'h0001;
				if (slow_tick) begin
					if (win_q == 5'(`MEAS_WINDOW_SLOW) - 5'h01) begin
						meas_q <= acc_q + {15'h0000, main_tick};
						meas_rdy_q <= 1'b1;
						acc_q <= 16'h0000;
						win_q <= 5'h00;
					end else begin
						win_q <= win_q + 5'h01;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	logic [5:0] lock_a_cnt_q, lock_b_cnt_q;
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			lock_a_cnt_q <= 6'h00;
			lock_b_cnt_q <= 6'h00;
			lock_a_q <= 1'b0;
			lock_b_q <= 1'b0;
		end else if (CLKEN_IN) begin
			if (cfg_a_wr) begin
				lock_a_cnt_q <= 6'h00;
				lock_a_q <= 1'b0;
			end else if (!lock_a_q && slow_tick) begin
				if (lock_a_cnt_q >= plla_q[13:8]) lock_a_q <= 1'b1;
				else lock_a_cnt_q <= lock_a_cnt_q + 6'h01;
			end
			if (cfg_b_wr) begin
				lock_b_cnt_q <= 6'h00;
				lock_b_q <= 1'b0;
			end else if (!lock_b_q && slow_tick) begin
				if (lock_b_cnt_q >= pllb_q[13:8]) lock_b_q <= 1'b1;
				else lock_b_cnt_q <= lock_b_cnt_q + 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Master clock: source pick, prescale, glitch-free switch
	mck_src_e src_q;
	logic src_clk, src_prev_q, mck_q_clk, usb_q;
	logic [6:0] master_prescaler_cnt_q;
	always_comb begin
		case (src_q)
			SRC_SLOW: src_clk = SLOW_CLK_IN;
			SRC_MAIN: src_clk = MAIN_CLK_IN;
			SRC_PLLA: src_clk = PLLA_CLK_IN;
			SRC_PLLB: src_clk = PLLB_CLK_IN;
			default: src_clk = SLOW_CLK_IN;
		endcase
	end
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			src_prev_q <= 1'b0;
			master_prescaler_cnt_q <= 7'h00;
			mck_q_clk <= 1'b0;
			mck_rdy_q <= 1'b1;
			src_q <= SRC_SLOW;
		end else if (CLKEN_IN) begin
			src_prev_q <= src_clk;
			if (mck_wr) begin
				mck_rdy_q <= 1'b0;
			end else if (!mck_rdy_q && !mck_q_clk) begin
				src_q <= mck_src_e'(mck_q[1:0]);
				master_prescaler_cnt_q <= 7'h00;
				mck_rdy_q <= 1'b1;
			end else if (src_clk != src_prev_q) begin
				if (mck_q[4:2] == 3'h0) begin
					mck_q_clk <= src_clk;
				end else if (rise(src_clk, src_prev_q)) begin
					if (master_prescaler_cnt_q + 7'h01 >= 7'(7'h01 << (mck_q[4:2] - 3'h1))) begin
						master_prescaler_cnt_q <= 7'h00;
						mck_q_clk <= ~mck_q_clk;
					end else begin
						master_prescaler_cnt_q <= master_prescaler_cnt_q + 7'h01;
					end
				end
			end
		end
	end
	assign MASTER_CLK_OUT = mck_q_clk;

	logic pllb_prev_q;
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pllb_prev_q <= 1'b0;
			usb_q <= 1'b0;
		end else if (CLKEN_IN) begin
			pllb_prev_q <= PLLB_CLK_IN;
			if (!pllb_q[`PLL_USB_BIT]) usb_q <= PLLB_CLK_IN;
			else if (rise(PLLB_CLK_IN, pllb_prev_q)) usb_q <= ~usb_q;
		end
	end
	assign USB_CLK_OUT = usb_q;

	////////////////////////////////////////////////////////////////
	set_wins_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		wr_en && PADDR_IN == `OFF_PCLK_SET |=> &(pclk_q | ~($past(PWDATA_IN) & `PCLK_VALID_MASK)))
		else $error("peripheral set lost");
	clear_drops_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		wr_en && PADDR_IN == `OFF_PCLK_CLR |=> (pclk_q & $past(PWDATA_IN) & `PCLK_VALID_MASK) == 32'h0)
		else $error("peripheral clear lost");
	low_bits_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		pclk_q[1:0] == 2'b00) else $error("reserved clock bits set");
	bypass_fast_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		CLKEN_IN && osc_byp |=> stable_q) else $error("bypass not stable");
	osc_off_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		CLKEN_IN && !osc_en && !osc_byp |=> !stable_q && !meas_rdy_q) else $error("stable kept");
	stable_wait_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		$rose(stable_q) && !$past(osc_byp) |-> $past(osc_cnt_q) + 12'h001 >= 12'($past(osc_q[15:8])) * 12'h008)
		else $error("stable early");
	lock_restart_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		cfg_a_wr |=> !lock_a_q ##0 lock_a_cnt_q == 6'h00) else $error("lock not restarted");
	usb_direct_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		CLKEN_IN && !pllb_q[`PLL_USB_BIT] |=> usb_q == $past(PLLB_CLK_IN)) else $error("usb clock wrong");
	switch_low_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		src_q != $past(src_q) |-> !mck_q_clk) else $error("switch while high");
	cover_lock_c: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) $rose(lock_a_q));
	cover_stable_c: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) $rose(stable_q));
	cover_meas_c: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) $rose(meas_rdy_q));
	cover_switch_c: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) $rose(mck_rdy_q));
	cover_usb_c: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) pllb_q[`PLL_USB_BIT] && $rose(usb_q));

	logic rd_setup;
	assign rd_setup = CLKEN_IN & PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
	lock_set_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!cfg_a_wr && !lock_a_q && slow_tick && lock_a_cnt_q >= plla_q[13:8] |=> lock_a_q)
		else $error("lock a not set");
	lock_b_set_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!cfg_b_wr && !lock_b_q && slow_tick && lock_b_cnt_q >= pllb_q[13:8] |=> lock_b_q)
		else $error("lock b not set");
	lock_count_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		$rose(lock_a_q) |-> $past(lock_a_cnt_q) >= $past(plla_q[13:8]))
		else $error("lock a early");
	startup_count_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!osc_byp && !stable_q && slow_tick && osc_cnt_q + 12'h001 < 12'(osc_q[15:8]) * 12'h008 |=> !stable_q)
		else $error("startup too short");
	meas_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!(slow_tick && (osc_en || osc_byp) && win_q == 5'(`MEAS_WINDOW_SLOW) - 5'h01) |=> $stable(meas_q))
		else $error("count moved inside window");
	meas_ready_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		slow_tick && (osc_en || osc_byp) && win_q == 5'(`MEAS_WINDOW_SLOW) - 5'h01 |=> meas_rdy_q)
		else $error("count not ready");
	ready_osc_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		meas_rdy_q |-> $past(osc_en || osc_byp))
		else $error("ready while disabled");
	src_follow_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		mck_rdy_q |-> src_q == mck_src_e'(mck_q[1:0]))
		else $error("source not applied");
	div_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		CLKEN_IN && mck_rdy_q && !mck_wr && mck_q[4:2] != 3'h0 && !rise(src_clk, src_prev_q) |=> $stable(mck_q_clk))
		else $error("divided clock moved early");
	switch_wait_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		CLKEN_IN && !mck_wr && !mck_rdy_q && mck_q_clk |=> !mck_rdy_q && $stable(src_q))
		else $error("switch did not wait");
	usb_half_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		CLKEN_IN && pllb_q[`PLL_USB_BIT] && !rise(PLLB_CLK_IN, pllb_prev_q) |=> $stable(usb_q))
		else $error("halved usb clock moved");
	status_read_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		rd_setup && PADDR_IN == `OFF_STATUS |=> PRDATA_OUT[`ST_STABLE_BIT] == $past(stable_q))
		else $error("stable flag not read");
	state_read_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		rd_setup && PADDR_IN == `OFF_PCLK_STATE |=> PRDATA_OUT == $past(pclk_q))
		else $error("clock state not read");
	freeze_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!CLKEN_IN |=> $stable(pclk_q) && $stable(osc_q) && $stable(mck_q_clk))
		else $error("state moved while frozen");
endmodule
`default_nettype wire

// [verification/clock_gen_and_master_clock_ctrl_bench.sv]
// Self-checking bench for the clock controller, driven over APB.
// Assumes the sources in src/ and a 200 MHz system clock.
`include "clkctl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_gen_and_master_clock_ctrl_bench;
	import clkctl_pkg::*;
	logic clk, nrst, clken, psel, penable, pwrite, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, periph_en, rd;
	logic pready, pslverr, slow, main_clk, plla, pllb, mck, usb, reserved;
	logic [1:0] ratio;
	word_t plla_cfg, pllb_cfg;
	logic [3:0] div_cnt = 4'h0, b_cnt = 4'h0;
	logic [31:0] mck_val [10];
	int mck_exp [10];
	int failures, tests_run, n, i;

	clkctl_top u_dut (.CLOCK_IN(clk), .NRST_IN(nrst), .CLKEN_IN(clken), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SLOW_CLK_IN(slow),
		.MAIN_CLK_IN(main_clk), .PLLA_CLK_IN(plla), .PLLB_CLK_IN(pllb), .PERIPH_CLK_EN_OUT(periph_en),
		.MASTER_CLK_OUT(mck), .USB_CLK_OUT(usb), .PLLA_CFG_OUT(plla_cfg), .PLLB_CFG_OUT(pllb_cfg),
		.PROC_RATIO_OUT(ratio), .CFG_RESERVED_OUT(reserved));

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Source clocks: slow 16, main 4, PLL A 8, PLL B 12 cycles
	always @(posedge clk) begin
		div_cnt <= div_cnt + 4'h1;
		b_cnt <= (b_cnt == 4'hB) ? 4'h0 : b_cnt + 4'h1;
	end
	assign slow = div_cnt[3];
	assign main_clk = div_cnt[1];
	assign plla = div_cnt[2];
	assign pllb = (b_cnt < 4'h6);

	////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			failures++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask

	task automatic wr(input logic [11:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data);
	endtask

	task automatic rdchk(input string what, input logic [11:0] addr, input logic [31:0] mask,
		input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		check(what, rd & mask, exp);
	endtask

	// Counts rising edges of the master or USB clock output
	task automatic count_edges(input logic sel_usb, input int cyc);
		logic prev, cur;
		n = 0;
		@(negedge clk);
		prev = sel_usb ? usb : mck;
		repeat (cyc) begin
			@(negedge clk);
			cur = sel_usb ? usb : mck;
			if (cur === 1'b1 && prev === 1'b0) n++;
			prev = cur;
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		clken = 1'b1;
		failures = 0;
		tests_run = 0;
		mck_val = '{32'h1, 32'h5, 32'h9, 32'hD, 32'h11, 32'h15, 32'h19, 32'h2, 32'h3, 32'h0};
		mck_exp = '{192, 96, 48, 24, 12, 6, 3, 96, 64, 48};
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rdchk("osc reset", `OFF_OSC_CTRL, 32'hFFFFFFFF, 32'h0);
		rdchk("plla reset", `OFF_PLL_A, 32'hFFFFFFFF, 32'h3F00);
		rdchk("pllb reset", `OFF_PLL_B, 32'hFFFFFFFF, 32'h3F00);
		rdchk("mck reset", `OFF_MCK_CFG, 32'hFFFFFFFF, 32'h0);
		rdchk("state reset", `OFF_PCLK_STATE, 32'hFFFFFFFF, 32'h0);
		rdchk("meas ready off", `OFF_FREQ_MEAS, 32'h10000, 32'h0);
		wr(`OFF_PCLK_SET, 32'hFFFFFFFF);
		rdchk("state all", `OFF_PCLK_STATE, 32'hFFFFFFFF, 32'hFFFFFFFC);
		check("periph enables", periph_en, 32'hFFFFFFFC);
		wr(`OFF_PCLK_CLR, 32'h000000F3);
		rdchk("state cleared", `OFF_PCLK_STATE, 32'hFFFFFFFF, 32'hFFFFFF0C);
		wr(`OFF_PCLK_SET, 32'h00000010);
		wr(`OFF_PCLK_CLR, 32'h0);
		wr(`OFF_PCLK_STATE, 32'h0);
		rdchk("state kept", `OFF_PCLK_STATE, 32'hFFFFFFFF, 32'hFFFFFF1C);
		@(posedge clk);
		clken <= 1'b0;
		wr(`OFF_PCLK_CLR, 32'h00000100);
		@(posedge clk);
		clken <= 1'b1;
		rdchk("state frozen", `OFF_PCLK_STATE, 32'hFFFFFFFF, 32'hFFFFFF1C);
		apb(1'b0, 12'h0FC, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h0);
		wr(`OFF_OSC_CTRL, 32'h2);
		repeat (4) @(posedge clk);
		rdchk("bypass stable", `OFF_STATUS, 32'h1, 32'h1);
		wr(`OFF_OSC_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		rdchk("stable dropped", `OFF_STATUS, 32'h1, 32'h0);
		wr(`OFF_OSC_CTRL, 32'h0201);
		repeat (218) @(posedge clk);
		rdchk("startup early", `OFF_STATUS, 32'h1, 32'h0);
		repeat (64) @(posedge clk);
		rdchk("startup done", `OFF_STATUS, 32'h1, 32'h1);
		repeat (640) @(posedge clk);
		rdchk("measure", `OFF_FREQ_MEAS, 32'h1FFFF, 32'h10040);
		wr(`OFF_PLL_A, 32'h00000301);
		rdchk("lock a early", `OFF_STATUS, 32'h2, 32'h0);
		repeat (128) @(posedge clk);
		rdchk("lock a", `OFF_STATUS, 32'h2, 32'h2);
		check("plla cfg", plla_cfg, 32'h00000301);
		check("range 00", {31'h0, reserved}, 32'h0);
		wr(`OFF_PLL_A, 32'h00004301);
		check("range 01", {31'h0, reserved}, 32'h1);
		wr(`OFF_PLL_A, 32'h0000C301);
		check("range 11", {31'h0, reserved}, 32'h1);
		wr(`OFF_PLL_A, 32'h07FF8300);
		check("range 10", {31'h0, reserved}, 32'h0);
		check("div mul cfg", plla_cfg, 32'h07FF8300);
		wr(`OFF_PLL_B, 32'h10000301);
		repeat (128) @(posedge clk);
		rdchk("lock b", `OFF_STATUS, 32'h4, 32'h4);
		check("pllb cfg", pllb_cfg, 32'h10000301);
		count_edges(1'b1, 768);
		check("usb halved", 32'(n), 32'd32);
		wr(`OFF_PLL_B, 32'h00000301);
		repeat (100) @(posedge clk);
		count_edges(1'b1, 768);
		check("usb direct", 32'(n), 32'd64);
		for (i = 0; i < 10; i++) begin
			wr(`OFF_MCK_CFG, mck_val[i]);
			repeat (300) @(posedge clk);
			count_edges(1'b0, 768);
			check("master edges", 32'(n), 32'(mck_exp[i]));
		end
		check("ratio 0", {30'h0, ratio}, 32'h0);
		for (i = 1; i < 4; i++) begin
			wr(`OFF_MCK_CFG, 32'h1 | (i << 8));
			check("ratio", {30'h0, ratio}, 32'(i));
		end
		wr(`OFF_MCK_CFG, 32'h1D);
		check("master_prescaler reserved", {31'h0, reserved}, 32'h1);
		rdchk("mck readback", `OFF_MCK_CFG, 32'hFFFFFFFF, 32'h1D);
		complete_run();
	end
endmodule
`default_nettype wire
